// ==== core/pcrs_pkg.sv ====
`default_nettype none
package pcrs_pkg;

   // Program counter and return stack geometry.
   localparam int unsigned PC_W       = 21;
   localparam int unsigned SP_W       = 5;
   localparam int unsigned STK_DEPTH  = 31;
   localparam int unsigned MAX_KBYTES = 2048;

   // Hard vectors.
   localparam logic [20:0] RESET_VECTOR = 21'h000000;
   localparam logic [20:0] HIGH_VECTOR  = 21'h000008;
   localparam logic [20:0] LOW_VECTOR   = 21'h000018;

   // Configuration word region: eight words, sixteen bytes at the top.
   localparam int unsigned CFG_WORDS    = 8;
   localparam int unsigned CFG_BYTES    = 16;
   localparam logic [20:0] CFG_BASE_32K  = 21'h007FF0;
   localparam logic [20:0] CFG_BASE_64K  = 21'h00FFF0;
   localparam logic [20:0] CFG_BASE_128K = 21'h01FFF0;
   localparam int unsigned FAULT_RST_BIT = 5;

   // Stack pointer register layout.
   localparam int unsigned FULL_BIT = 7;
   localparam int unsigned UNF_BIT  = 6;

   // Commands from the decoder, interrupt logic and register accesses.
   typedef enum logic [3:0] {
      OP_NONE   = 4'h0,
      OP_STEP   = 4'h1,
      OP_JUMP   = 4'h2,
      OP_CALL   = 4'h3,
      OP_INT_HI = 4'h4,
      OP_INT_LO = 4'h5,
      OP_RETURN = 4'h6,
      OP_UNLINK = 4'h7,
      OP_SFR_WR = 4'h8,
      OP_SFR_RD = 4'h9
   } pcrs_op_t;

   // Register selector for software accesses.
   typedef enum logic [2:0] {
      SEL_PC_LO  = 3'h0,
      SEL_LATH   = 3'h1,
      SEL_LATU   = 3'h2,
      SEL_SP     = 3'h3,
      SEL_TOP_LO = 3'h4,
      SEL_TOP_HI = 3'h5,
      SEL_TOP_UP = 3'h6
   } pcrs_sel_t;

   // Loader and run states, one-hot.
   typedef enum logic [2:0] {
      ST_ISSUE   = 3'h1,
      ST_CAPTURE = 3'h2,
      ST_RUN     = 3'h4
   } pcrs_state_t;

endpackage
`default_nettype wire

// ==== core/pcrs_stack_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcrs_stack_mem #(
   parameter int unsigned DEPTH = 31,
   parameter int unsigned WIDTH = 21,
   parameter int unsigned AW    = 5
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata_q
);

   // Index zero has no storage; entries 1..DEPTH live at idx-1.
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_d;

   initial begin
      if (DEPTH + 1 > (1 << AW)) begin
         $error("pcrs_stack_mem: DEPTH does not fit the pointer");
      end
   end

   // Write-through keeps rdata_q equal to the entry at raddr.
   always_comb begin
      rdata_d = '0;
      if (raddr != '0) begin
         rdata_d = mem[raddr - AW'(1)];
         if (we && waddr == raddr) begin
            rdata_d = wdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (we && waddr != '0) begin
         mem[waddr - AW'(1)] <= wdata;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

endmodule
`default_nettype wire

// ==== core/pcrs_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcrs_core #(
   parameter int unsigned MEM_KBYTES = 128
) (
   input  wire logic                    clock,
   input  wire logic                    sys_rst,
   input  wire logic                    por_rst,
   input  wire pcrs_pkg::pcrs_op_t      op,
   input  wire logic [20:0]             jump_target,
   input  wire logic                    ext_instr_enable,
   input  wire pcrs_pkg::pcrs_sel_t     sfr_sel,
   input  wire logic [7:0]              sfr_wdata,
   output logic      [7:0]              sfr_rdata_q,
   input  wire logic [15:0]             pmem_rdata,
   output logic      [20:0]             pmem_addr_q,
   output logic      [15:0]             fetch_data_q,
   output logic      [20:0]             pc_q,
   output logic      [7:0]              pc_high_latch_q,
   output logic      [4:0]              pc_upper_latch_q,
   output logic      [4:0]              return_stack_pointer_q,
   output logic                         stack_full_flag_q,
   output logic                         stack_underflow_flag_q,
   output logic                         stack_fault_reset_enable_q,
   output logic                         overflow_reset_q,
   output logic                         cfg_busy_q,
   output logic      [127:0]            config_bytes_q
);

   localparam logic [21:0] MEM_BYTES = 22'(MEM_KBYTES * 1024);
   localparam logic [20:0] CFG_BASE  = (MEM_KBYTES == 32) ?
      pcrs_pkg::CFG_BASE_32K : (MEM_KBYTES == 64) ?
      pcrs_pkg::CFG_BASE_64K : pcrs_pkg::CFG_BASE_128K;
   localparam logic [4:0]  SP_TOP    = 5'(pcrs_pkg::STK_DEPTH);

   // Only the three supported memory sizes have a known region.
   initial begin
      if (MEM_KBYTES != 32 && MEM_KBYTES != 64 && MEM_KBYTES != 128) begin
         $error("pcrs_core: MEM_KBYTES must be 32, 64 or 128");
      end
   end

   pcrs_pkg::pcrs_state_t state_q, state_d;
   logic [2:0]   cfg_idx_q, cfg_idx_d;
   logic [20:0]  pc_d, pmem_addr_d;
   logic [7:0]   lath_d, sfr_rdata_d;
   logic [4:0]   latu_d, sp_d;
   logic         full_d, unf_d, fault_rst_d, ovf_d, busy_d;
   logic [127:0] cfg_d;
   logic [15:0]  fetch_d;
   logic         mem_we;
   logic [4:0]   mem_waddr;
   logic [20:0]  mem_wdata, stack_top;

   // Stack storage; stack_top always mirrors the entry under the pointer.
   pcrs_stack_mem #(
      .DEPTH (pcrs_pkg::STK_DEPTH),
      .WIDTH (pcrs_pkg::PC_W),
      .AW    (pcrs_pkg::SP_W)
   ) u_stack (
      .clock   (clock),
      .sys_rst (sys_rst),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .raddr   (sp_d),
      .rdata_q (stack_top)
   );

   // Next-state logic for loader, counter, latches and stack.
   always_comb begin
      logic        push_req;
      logic        pop_req;
      logic [20:0] push_val;
      push_req    = 1'b0;
      pop_req     = 1'b0;
      push_val    = pc_q;
      state_d     = state_q;
      cfg_idx_d   = cfg_idx_q;
      pc_d        = pc_q;
      lath_d      = pc_high_latch_q;
      latu_d      = pc_upper_latch_q;
      sp_d        = return_stack_pointer_q;
      full_d      = stack_full_flag_q;
      unf_d       = stack_underflow_flag_q;
      fault_rst_d = stack_fault_reset_enable_q;
      ovf_d       = 1'b0;
      cfg_d       = config_bytes_q;
      sfr_rdata_d = sfr_rdata_q;
      mem_we      = 1'b0;
      mem_waddr   = return_stack_pointer_q;
      mem_wdata   = stack_top;
      pmem_addr_d = pmem_addr_q;
      // Past the implemented top the fetch reads as a no-operation.
      fetch_d     = ({1'b0, pmem_addr_q} < MEM_BYTES) ? pmem_rdata
                                                      : 16'h0000;
      case (state_q)
         pcrs_pkg::ST_ISSUE: begin
            pmem_addr_d = CFG_BASE + {17'h00000, cfg_idx_q, 1'b0};
            state_d     = pcrs_pkg::ST_CAPTURE;
         end
         pcrs_pkg::ST_CAPTURE: begin
            // Low byte sits at the lower address.
            cfg_d[cfg_idx_q*16 +: 16] = pmem_rdata;
            if (cfg_idx_q == 3'h0) begin
               fault_rst_d = pmem_rdata[pcrs_pkg::FAULT_RST_BIT];
            end
            if (cfg_idx_q == 3'(pcrs_pkg::CFG_WORDS - 1)) begin
               state_d = pcrs_pkg::ST_RUN;
            end else begin
               cfg_idx_d = cfg_idx_q + 3'h1;
               state_d   = pcrs_pkg::ST_ISSUE;
            end
         end
         pcrs_pkg::ST_RUN: begin
            case (op)
               pcrs_pkg::OP_STEP: begin
                  pc_d = pc_q + 21'h000002;
               end
               pcrs_pkg::OP_JUMP: begin
                  pc_d = {jump_target[20:1], 1'b0};
               end
               pcrs_pkg::OP_CALL: begin
                  push_req = 1'b1;
                  push_val = pc_q + 21'h000002;
                  pc_d     = {jump_target[20:1], 1'b0};
               end
               pcrs_pkg::OP_INT_HI: begin
                  push_req = 1'b1;
                  pc_d     = pcrs_pkg::HIGH_VECTOR;
               end
               pcrs_pkg::OP_INT_LO: begin
                  push_req = 1'b1;
                  pc_d     = pcrs_pkg::LOW_VECTOR;
               end
               pcrs_pkg::OP_RETURN: begin
                  pop_req = 1'b1;
               end
               pcrs_pkg::OP_UNLINK: begin
                  // Without the extended set the opcode is a plain step.
                  if (ext_instr_enable) begin
                     pop_req = 1'b1;
                  end else begin
                     pc_d = pc_q + 21'h000002;
                  end
               end
               pcrs_pkg::OP_SFR_WR: begin
                  case (sfr_sel)
                     pcrs_pkg::SEL_PC_LO: begin
                        pc_d = {pc_upper_latch_q, pc_high_latch_q,
                                sfr_wdata[7:1], 1'b0};
                     end
                     pcrs_pkg::SEL_LATH: lath_d = sfr_wdata;
                     pcrs_pkg::SEL_LATU: latu_d = sfr_wdata[4:0];
                     pcrs_pkg::SEL_SP: begin
                        // Flags only clear; writing a one keeps them.
                        sp_d   = sfr_wdata[4:0];
                        full_d = full_d & sfr_wdata[pcrs_pkg::FULL_BIT];
                        unf_d  = unf_d & sfr_wdata[pcrs_pkg::UNF_BIT];
                     end
                     pcrs_pkg::SEL_TOP_LO, pcrs_pkg::SEL_TOP_HI,
                     pcrs_pkg::SEL_TOP_UP: begin
                        mem_we = (return_stack_pointer_q != 5'h00);
                        case (sfr_sel)
                           pcrs_pkg::SEL_TOP_LO: mem_wdata[7:0]  = sfr_wdata;
                           pcrs_pkg::SEL_TOP_HI: mem_wdata[15:8] = sfr_wdata;
                           default: mem_wdata[20:16] = sfr_wdata[4:0];
                        endcase
                     end
                     default: begin
                     end
                  endcase
               end
               pcrs_pkg::OP_SFR_RD: begin
                  case (sfr_sel)
                     pcrs_pkg::SEL_PC_LO: begin
                        sfr_rdata_d = pc_q[7:0];
                        lath_d      = pc_q[15:8];
                        latu_d      = pc_q[20:16];
                     end
                     pcrs_pkg::SEL_LATH: sfr_rdata_d = pc_high_latch_q;
                     pcrs_pkg::SEL_LATU: begin
                        sfr_rdata_d = {3'h0, pc_upper_latch_q};
                     end
                     pcrs_pkg::SEL_SP: begin
                        sfr_rdata_d = {stack_full_flag_q,
                                       stack_underflow_flag_q, 1'b0,
                                       return_stack_pointer_q};
                     end
                     pcrs_pkg::SEL_TOP_LO: sfr_rdata_d = stack_top[7:0];
                     pcrs_pkg::SEL_TOP_HI: sfr_rdata_d = stack_top[15:8];
                     pcrs_pkg::SEL_TOP_UP: begin
                        sfr_rdata_d = {3'h0, stack_top[20:16]};
                     end
                     default: sfr_rdata_d = 8'h00;
                  endcase
               end
               default: begin
               end
            endcase
            if (push_req) begin
               if (return_stack_pointer_q != SP_TOP) begin
                  sp_d      = return_stack_pointer_q + 5'h01;
                  mem_we    = 1'b1;
                  mem_waddr = sp_d;
                  mem_wdata = push_val;
                  if (sp_d == SP_TOP) begin
                     full_d = 1'b1;
                     if (stack_fault_reset_enable_q) begin
                        sp_d  = 5'h00;
                        ovf_d = 1'b1;
                     end
                  end
               end else begin
                  full_d = 1'b1;
               end
            end
            if (pop_req) begin
               if (return_stack_pointer_q == 5'h00) begin
                  // The counter goes to the reset vector and the underflow flag sets; nothing else is reset.
                  pc_d  = pcrs_pkg::RESET_VECTOR;
                  unf_d = 1'b1;
               end else begin
                  pc_d = {stack_top[20:1], 1'b0};
                  sp_d = return_stack_pointer_q - 5'h01;
               end
            end
            pmem_addr_d = pc_d;
         end
         default: begin
            state_d = pcrs_pkg::ST_ISSUE;
         end
      endcase
      busy_d = (state_d != pcrs_pkg::ST_RUN);
   end

   // Ordinary reset state; the loader restarts on every sys_rst.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q                    <= pcrs_pkg::ST_ISSUE;
         cfg_idx_q                  <= 3'h0;
         pc_q                       <= pcrs_pkg::RESET_VECTOR;
         pc_high_latch_q            <= 8'h00;
         pc_upper_latch_q           <= 5'h00;
         return_stack_pointer_q     <= 5'h00;
         stack_fault_reset_enable_q <= 1'b1;
         overflow_reset_q           <= 1'b0;
         cfg_busy_q                 <= 1'b1;
         config_bytes_q             <= 128'h0;
         sfr_rdata_q                <= 8'h00;
         pmem_addr_q                <= 21'h000000;
         fetch_data_q               <= 16'h0000;
      end else begin
         state_q                    <= state_d;
         cfg_idx_q                  <= cfg_idx_d;
         pc_q                       <= pc_d;
         pc_high_latch_q            <= lath_d;
         pc_upper_latch_q           <= latu_d;
         return_stack_pointer_q     <= sp_d;
         stack_fault_reset_enable_q <= fault_rst_d;
         overflow_reset_q           <= ovf_d;
         cfg_busy_q                 <= busy_d;
         config_bytes_q             <= cfg_d;
         sfr_rdata_q                <= sfr_rdata_d;
         pmem_addr_q                <= pmem_addr_d;
         fetch_data_q               <= fetch_d;
      end
   end

   // The flags survive every reset except power-on, so they have their own.
   always_ff @(posedge clock or posedge por_rst) begin
      if (por_rst) begin
         stack_full_flag_q      <= 1'b0;
         stack_underflow_flag_q <= 1'b0;
      end else begin
         stack_full_flag_q      <= full_d;
         stack_underflow_flag_q <= unf_d;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst || por_rst);

   logic run;
   assign run = (state_q == pcrs_pkg::ST_RUN);

   pc_align_a: assert property (pc_q[0] == 1'b0)
      else $error("program counter lost word alignment");
   step_adv_a: assert property (run && op == pcrs_pkg::OP_STEP
      |=> pc_q == $past(pc_q) + 21'h000002)
      else $error("step did not advance by two");
   low_write_a: assert property (run && op == pcrs_pkg::OP_SFR_WR &&
      sfr_sel == pcrs_pkg::SEL_PC_LO |=> pc_q[20:8] ==
      {$past(pc_upper_latch_q), $past(pc_high_latch_q)})
      else $error("low byte write did not move latches");
   low_read_a: assert property (run && op == pcrs_pkg::OP_SFR_RD &&
      sfr_sel == pcrs_pkg::SEL_PC_LO |=>
      {8'h00, pc_upper_latch_q, pc_high_latch_q} == ($past(pc_q) >> 8))
      else $error("low byte read did not fill latches");
   latch_keep_a: assert property (run && (op == pcrs_pkg::OP_CALL ||
      op == pcrs_pkg::OP_RETURN || op == pcrs_pkg::OP_JUMP)
      |=> $stable(pc_high_latch_q) && $stable(pc_upper_latch_q))
      else $error("call or return touched the latches");
   push_ret_a: assert property (run && op == pcrs_pkg::OP_CALL &&
      return_stack_pointer_q < 5'h1E |=> return_stack_pointer_q ==
      $past(return_stack_pointer_q) + 5'h01 &&
      stack_top == $past(pc_q) + 21'h000002)
      else $error("push did not store the return address");
   under_flow_a: assert property (run && op == pcrs_pkg::OP_RETURN &&
      return_stack_pointer_q == 5'h00 |=> pc_q == 21'h000000 &&
      stack_underflow_flag_q && return_stack_pointer_q == 5'h00)
      else $error("underflow handling wrong");
   full_hold_a: assert property (run && op == pcrs_pkg::OP_CALL &&
      !stack_fault_reset_enable_q && return_stack_pointer_q == SP_TOP
      |=> return_stack_pointer_q == SP_TOP && stack_full_flag_q)
      else $error("pointer left 31 on overflow");
   ovf_reset_a: assert property (run && op == pcrs_pkg::OP_CALL &&
      stack_fault_reset_enable_q && return_stack_pointer_q == 5'h1E
      |=> overflow_reset_q && stack_full_flag_q &&
      return_stack_pointer_q == 5'h00)
      else $error("overflow reset not raised");
   int_vec_a: assert property (run && op == pcrs_pkg::OP_INT_LO
      |=> pc_q == pcrs_pkg::LOW_VECTOR)
      else $error("low interrupt vector wrong");
   fetch_zero_a: assert property ({1'b0, pmem_addr_q} >= MEM_BYTES
      |=> fetch_data_q == 16'h0000)
      else $error("fetch beyond memory not zero");
   cfg_done_a: assert property (state_q == pcrs_pkg::ST_ISSUE &&
      cfg_idx_q == 3'h0 |-> ##[1:16] !cfg_busy_q)
      else $error("configuration load did not finish");

   full_cov_c: cover property (run && overflow_reset_q);
   under_cov_c: cover property (run && $rose(stack_underflow_flag_q));
   call_ret_c: cover property (run && op == pcrs_pkg::OP_CALL ##[1:20]
      op == pcrs_pkg::OP_RETURN);

endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {
      pcrs_pkg::pcrs_op_t op;
      logic [20:0]        tgt;
      logic               ext;
      logic [20:0]        pc;
      logic [4:0]         sp;
   } pcrs_row_t;
   logic                clock = 1'b0;
   logic                sys_rst = 1'b1;
   logic                por_rst = 1'b1;
   pcrs_pkg::pcrs_op_t  op = pcrs_pkg::OP_NONE;
   logic [20:0]         jump_target = 21'h000000;
   logic                ext_instr_enable = 1'b0;
   pcrs_pkg::pcrs_sel_t sfr_sel = pcrs_pkg::SEL_PC_LO;
   logic [7:0]          sfr_wdata = 8'h00;
   logic [7:0]          mask = 8'h00;
   logic [7:0]          sfr_rdata_q, lath_q;
   logic [15:0]         fetch_data_q;
   logic [20:0]         pmem_addr_q, pc_q;
   logic [4:0]          latu_q, sp_q;
   logic                full_q, unf_q, stv_q, ovf_q, busy_q;
   logic [127:0]        cfg_q;
   int                  n_fail = 0;
   int                  n_compared = 0;
   // Ordinary traffic: steps, calls, interrupts, returns, unlinks, jump.
   pcrs_row_t rows [13] = '{
      '{pcrs_pkg::OP_STEP,   21'h000000, 1'b0, 21'h000002, 5'h00},
      '{pcrs_pkg::OP_CALL,   21'h001235, 1'b0, 21'h001234, 5'h01},
      '{pcrs_pkg::OP_STEP,   21'h000000, 1'b0, 21'h001236, 5'h01},
      '{pcrs_pkg::OP_CALL,   21'h000100, 1'b0, 21'h000100, 5'h02},
      '{pcrs_pkg::OP_INT_HI, 21'h000000, 1'b0, 21'h000008, 5'h03},
      '{pcrs_pkg::OP_RETURN, 21'h000000, 1'b0, 21'h000100, 5'h02},
      '{pcrs_pkg::OP_RETURN, 21'h000000, 1'b0, 21'h001238, 5'h01},
      '{pcrs_pkg::OP_INT_LO, 21'h000000, 1'b0, 21'h000018, 5'h02},
      '{pcrs_pkg::OP_UNLINK, 21'h000000, 1'b0, 21'h00001A, 5'h02},
      '{pcrs_pkg::OP_UNLINK, 21'h000000, 1'b1, 21'h001238, 5'h01},
      '{pcrs_pkg::OP_JUMP,   21'h1FFFFE, 1'b0, 21'h1FFFFE, 5'h01},
      '{pcrs_pkg::OP_RETURN, 21'h000000, 1'b0, 21'h000004, 5'h00},
      '{pcrs_pkg::OP_RETURN, 21'h000000, 1'b0, 21'h000000, 5'h00}};

   // Program memory answers at once; each byte shows its own address, so
   // a swapped byte order shows up, and the mask steers the fault bit.
   function automatic logic [15:0] pm(input logic [20:0] a);
      return {a[7:0] | 8'h01, a[7:0] ^ mask};
   endfunction
   wire logic [15:0] pmem_rdata = pm(pmem_addr_q);

   pcrs_core #(.MEM_KBYTES(32)) dut_u (
      .clock(clock), .sys_rst(sys_rst), .por_rst(por_rst), .op(op),
      .jump_target(jump_target), .ext_instr_enable(ext_instr_enable),
      .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata),
      .sfr_rdata_q(sfr_rdata_q), .pmem_rdata(pmem_rdata),
      .pmem_addr_q(pmem_addr_q), .fetch_data_q(fetch_data_q), .pc_q(pc_q),
      .pc_high_latch_q(lath_q), .pc_upper_latch_q(latu_q),
      .return_stack_pointer_q(sp_q), .stack_full_flag_q(full_q),
      .stack_underflow_flag_q(unf_q), .stack_fault_reset_enable_q(stv_q),
      .overflow_reset_q(ovf_q), .cfg_busy_q(busy_q), .config_bytes_q(cfg_q));

   // The clock toggles every half period of 25 ns.
   always #25 clock = ~clock;

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Reset for three cycles, then wait a bounded time for the loader.
   task automatic rst(input logic por, input logic [7:0] m = 8'h00);
      int k;
      @(posedge clock);
      sys_rst <= 1'b1;
      por_rst <= por;
      mask    <= m;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      por_rst <= 1'b0;
      for (k = 0; busy_q !== 1'b0; k++) begin
         @(posedge clock);
         #1;
         if (k > 40) begin
            n_fail++;
            report_and_stop();
         end
      end
   endtask

   // One command for one cycle; outputs are sampled after the taking edge.
   task automatic do_op(input pcrs_pkg::pcrs_op_t o, input logic [20:0] t,
                        input pcrs_pkg::pcrs_sel_t s = pcrs_pkg::SEL_PC_LO,
                        input logic [7:0] w = 8'h00, input logic e = 1'b0);
      @(posedge clock);
      op <= o;
      jump_target <= t;
      sfr_sel <= s;
      sfr_wdata <= w;
      ext_instr_enable <= e;
      @(posedge clock);
      op <= pcrs_pkg::OP_NONE;
      #1;
   endtask

   initial begin
      rst(1'b1);
      chk(stv_q, 1);
      chk(cfg_q[7:0], 8'hF0);
      chk(cfg_q[127:120], 8'hFF);
      foreach (rows[i]) begin
         do_op(rows[i].op, rows[i].tgt, pcrs_pkg::SEL_PC_LO, 8'h00,
               rows[i].ext);
         chk(pc_q, rows[i].pc);
         chk(sp_q, rows[i].sp);
         chk(pmem_addr_q, rows[i].pc);
         @(posedge clock);
         #1;
         chk(fetch_data_q, (rows[i].pc >= 21'h008000) ? 16'h0000
             : pm(rows[i].pc));
      end
      chk(unf_q, 1);
      chk(busy_q, 0);
      do_op(pcrs_pkg::OP_SFR_WR, 0, pcrs_pkg::SEL_LATH, 8'h12);
      do_op(pcrs_pkg::OP_SFR_WR, 0, pcrs_pkg::SEL_LATU, 8'h03);
      chk(pc_q, 0);
      do_op(pcrs_pkg::OP_SFR_WR, 0, pcrs_pkg::SEL_PC_LO, 8'h57);
      chk(pc_q, 21'h031256);
      do_op(pcrs_pkg::OP_CALL, 21'h000400);
      chk({lath_q, 3'b000, latu_q}, 16'h1203);
      do_op(pcrs_pkg::OP_STEP, 0);
      do_op(pcrs_pkg::OP_STEP, 0);
      do_op(pcrs_pkg::OP_SFR_RD, 0, pcrs_pkg::SEL_PC_LO);
      chk(sfr_rdata_q, 8'h04);
      chk({lath_q, 3'b000, latu_q}, 16'h0400);
      do_op(pcrs_pkg::OP_SFR_RD, 0, pcrs_pkg::SEL_LATH);
      chk(sfr_rdata_q, 8'h04);
      // No interrupt is raised while the stack registers are touched.
      do_op(pcrs_pkg::OP_SFR_RD, 0, pcrs_pkg::SEL_TOP_LO);
      chk(sfr_rdata_q, 8'h58);
      do_op(pcrs_pkg::OP_SFR_RD, 0, pcrs_pkg::SEL_TOP_HI);
      chk(sfr_rdata_q, 8'h12);
      do_op(pcrs_pkg::OP_SFR_RD, 0, pcrs_pkg::SEL_TOP_UP);
      chk(sfr_rdata_q, 8'h03);
      do_op(pcrs_pkg::OP_SFR_RD, 0, pcrs_pkg::SEL_SP);
      chk(sfr_rdata_q, 8'h41);
      do_op(pcrs_pkg::OP_SFR_WR, 0, pcrs_pkg::SEL_SP, 8'h01);
      chk({unf_q, sp_q}, 6'h01);
      do_op(pcrs_pkg::OP_SFR_WR, 0, pcrs_pkg::SEL_TOP_LO, 8'hA0);
      do_op(pcrs_pkg::OP_SFR_WR, 0, pcrs_pkg::SEL_TOP_HI, 8'h34);
      do_op(pcrs_pkg::OP_SFR_WR, 0, pcrs_pkg::SEL_TOP_UP, 8'h01);
      do_op(pcrs_pkg::OP_NONE, 0);
      do_op(pcrs_pkg::OP_RETURN, 0);
      chk(pc_q, 21'h0134A0);
      // Overflow with the fault reset on, then a reset that keeps flags.
      for (int i = 0; i < 31; i++) begin
         do_op(pcrs_pkg::OP_CALL, 21'h000200 + 21'(4 * i));
         chk(ovf_q, (i == 30) ? 1 : 0);
         chk(sp_q, (i == 30) ? 0 : i + 1);
      end
      chk(full_q, 1);
      rst(1'b0);
      chk({full_q, sp_q}, 6'h20);
      // Power-on reset with the fault reset bit cleared in the image.
      rst(1'b1, 8'h20);
      chk({full_q, stv_q}, 0);
      chk(cfg_q[15:0], 16'hF1D0);
      for (int i = 0; i < 32; i++) begin
         do_op(pcrs_pkg::OP_CALL, 21'h000200 + 21'(4 * i));
         chk(ovf_q, 0);
      end
      chk({full_q, sp_q}, 6'h3F);
      do_op(pcrs_pkg::OP_RETURN, 0);
      chk(pc_q, 21'h000276);
      chk(sp_q, 30);
      report_and_stop();
   end
endmodule
`default_nettype wire
